/* File: hdl/rfs_regfile.sv */
/*
  rfs_regfile: 32 working registers, three pointers, stack pointer,
  extended pointer page and the shared 8-bit temporary byte.
  assumes: one core clock, synchronous reset; the datapath drives
  requests for one cycle and takes registered answers the next cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rfs_cfg.svh"
module rfs_regfile
  import rfs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [4:0]  rdAddrA,
  input  wire logic [4:0]  rdAddrB,
  input  wire logic        rdWide,
  input  wire logic        wrEn,
  input  wire logic        wrWide,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        ptrEn,
  input  wire logic [1:0]  ptrSel,
  input  wire rfs_pmode_t  ptrMode,
  input  wire logic [5:0]  ptrDisp,
  input  wire rfs_stk_t    stkOp,
  input  wire logic        pmEn,
  input  wire logic        pmExt,
  input  wire logic        dsEn,
  input  wire logic        dsWe,
  input  wire logic        dsIsIo,
  input  wire logic [15:0] dsAddr,
  input  wire logic [7:0]  dsWdata,
  input  wire logic        tmpWe,
  input  wire logic [7:0]  tmpWdata,
  output var  logic [15:0] operandA,
  output var  logic [7:0]  operandB,
  output var  logic [15:0] ptrAddr,
  output var  logic [23:0] pmAddr,
  output var  logic [7:0]  dsRdata,
  output var  logic        dsHit,
  output var  logic [15:0] stackPtr,
  output var  logic [7:0]  tmpByte
);
  logic [7:0] regs [`RFS_NREG];
  logic [7:0] page;
  rfs_ptr_if  pif ();

  rfs_ptr_unit u_ptr (
    .pif (pif.unit)
  );

  // ==========================================
  // data-space decode
  wire [15:0] ioAddr   = {10'h000, dsAddr[5:0]} + `RFS_IO_OFS;
  wire [15:0] dsEff    = dsIsIo ? ioAddr : dsAddr;
  wire        isReg    = dsEff <= `RFS_REG_TOP;
  wire        isStkLo  = dsEff == `RFS_A_STK_LO;
  wire        isStkHi  = dsEff == `RFS_A_STK_HI;
  wire        isPage   = dsEff == `RFS_A_PAGE;
  wire        dsWrite  = dsEn && dsWe;
  wire        dsRead   = dsEn && !dsWe;
  wire [7:0]  pageRead = page & `RFS_PAGE_MASK;

  // high byte read returns the byte caught by the preceding low read
  wire [7:0]  dsMux    = isReg  ? regs[dsEff[4:0]] :
                         isStkLo ? stackPtr[7:0] :
                         isStkHi ? tmpByte :
                         isPage ? pageRead : 8'h00;

  // ==========================================
  // pointer selection and arithmetic
  wire [4:0]  ptrLo    = `RFS_PTR_BASE + {2'b00, ptrSel, 1'b0};
  wire [4:0]  ptrHi    = ptrLo | 5'h01;
  wire        ptrBack  = ptrEn && ptrMode != PTR_DISP;
  wire [15:0] zPtr     = {regs[5'h1f], regs[5'h1e]};

  assign pif.ptrValue = {regs[ptrHi], regs[ptrLo]};
  assign pif.ptrMode  = ptrMode;
  assign pif.ptrDisp  = ptrDisp;
  assign pif.stkValue = stackPtr;
  assign pif.stkOp    = stkOp;

  // ==========================================
  // operand reads: sampled before this cycle's write lands
  wire [4:0]  rdPairLo = {rdAddrA[4:1], 1'b0};
  wire [4:0]  rdPairHi = {rdAddrA[4:1], 1'b1};
  wire [15:0] rdWideV  = {regs[rdPairHi], regs[rdPairLo]};
  wire [15:0] curA     = rdWide ? rdWideV : {8'h00, regs[rdAddrA]};
  wire [7:0]  curB     = regs[rdAddrB];

  always_ff @(posedge clock) begin
    if (reset) begin
      operandA <= 16'h0000;
      operandB <= 8'h00;
    end else begin
      operandA <= curA;
      operandB <= curB;
    end
  end

  // ==========================================
  // working registers, one slice per entry
  // priority: datapath result, then data-space store, then pointer update
  for (genvar i = 0; i < `RFS_NREG; i++) begin : g_reg
    localparam logic [4:0] IDX = 5'(i);
    wire       wrHit  = wrEn && (wrWide ? wrAddr[4:1] == IDX[4:1]
                                        : wrAddr == IDX);
    wire       dsHitI = dsWrite && isReg && dsEff[4:0] == IDX;
    wire       ptHitI = ptrBack && ptrLo[4:1] == IDX[4:1];
    wire [7:0] wrByte = (wrWide && IDX[0]) ? wrData[15:8] : wrData[7:0];
    wire [7:0] ptByte = IDX[0] ? pif.newPtr[15:8] : pif.newPtr[7:0];
    always_ff @(posedge clock) begin
      if (reset) begin
        regs[i] <= `RFS_REG_RST;
      end else if (wrHit) begin
        regs[i] <= wrByte;
      end else if (dsHitI) begin
        regs[i] <= dsWdata;
      end else if (ptHitI) begin
        regs[i] <= ptByte;
      end
    end
  end

  // ==========================================
  // pointer and program-memory addresses
  wire [23:0] next_pmAddr = pmExt ? {pageRead, zPtr}
                                  : {8'h00, zPtr};

  always_ff @(posedge clock) begin
    if (reset) begin
      ptrAddr <= 16'h0000;
      pmAddr  <= 24'h000000;
    end else begin
      if (ptrEn) begin
        ptrAddr <= pif.effAddr;
      end
      if (pmEn) begin
        pmAddr <= next_pmAddr;
      end
    end
  end

  // ==========================================
  // temporary byte, stack pointer, page register
  wire        stkWrite = dsWrite && isStkHi;
  wire [15:0] stkLoad  = {dsWdata, tmpByte} & `RFS_STK_MASK;
  wire [7:0]  next_tmpByte = (dsWrite && isStkLo) ? dsWdata :
                             (dsRead && isStkLo)  ? stackPtr[15:8] :
                             tmpWdata;
  wire        tmpLoad  = (dsEn && isStkLo) || tmpWe;

  always_ff @(posedge clock) begin
    if (reset) begin
      tmpByte  <= 8'h00;
      stackPtr <= `RFS_STK_RST;
      page     <= `RFS_PAGE_RST;
      dsRdata  <= 8'h00;
      dsHit    <= 1'b0;
    end else begin
      if (tmpLoad) begin
        tmpByte <= next_tmpByte;
      end
      if (stkWrite) begin
        stackPtr <= stkLoad;
      end else if (stkOp != STK_NONE) begin
        stackPtr <= pif.next_stk;
      end
      if (dsWrite && isPage) begin
        page <= dsWdata & `RFS_PAGE_MASK;
      end
      dsRdata <= dsRead ? dsMux : 8'h00;
      dsHit   <= dsEn && (isReg || isStkLo || isStkHi || isPage);
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_stack_reset: assert property (
    disable iff (1'b0) reset |=> stackPtr == `RFS_STK_RST)
    else $error("stack pointer not loaded on reset");

  a_page_reset: assert property (
    disable iff (1'b0) reset |=> page == `RFS_PAGE_RST)
    else $error("page register not cleared on reset");

  a_stack_push: assert property (
    stkOp == STK_PUSH && !stkWrite
      |=> stackPtr == ((($past(stackPtr)) - 16'h0001) & `RFS_STK_MASK))
    else $error("push did not lower stack pointer by one");

  a_stack_pop: assert property (
    stkOp == STK_POP && !stkWrite
      |=> stackPtr == ((($past(stackPtr)) + 16'h0001) & `RFS_STK_MASK))
    else $error("pop did not raise stack pointer by one");

  a_stack_call: assert property (
    stkOp == STK_CALL && !stkWrite
      |=> stackPtr == ((($past(stackPtr)) - 16'h0002) & `RFS_STK_MASK))
    else $error("call did not lower stack pointer by two");

  a_stack_return: assert property (
    stkOp == STK_RETURN && !stkWrite
      |=> stackPtr == ((($past(stackPtr)) + 16'h0002) & `RFS_STK_MASK))
    else $error("return did not raise stack pointer by two");

  a_stack_top_zero: assert property (
    stackPtr[15:13] == 3'b000)
    else $error("stack pointer read-only bits not zero");

  a_page_unused: assert property (
    dsRead && isPage |=> (dsRdata & ~`RFS_PAGE_MASK) == 8'h00)
    else $error("unimplemented page bits read non-zero");

  // a low store must park in the temp byte and leave the pointer alone
  a_lo_write_temp: assert property (
    dsWrite && isStkLo && stkOp == STK_NONE
      |=> tmpByte == $past(dsWdata) && stackPtr == $past(stackPtr))
    else $error("low write did not go to the temp byte only");

  a_hi_write_pair: assert property (
    stkWrite |=> stackPtr == (({$past(dsWdata), $past(tmpByte)}) & `RFS_STK_MASK))
    else $error("high write did not commit temp into low half");

  a_lo_read_latch: assert property (
    dsRead && isStkLo ##1 dsRead && isStkHi && !tmpWe
      |=> dsRdata == $past(stackPtr[15:8], 2))
    else $error("high read did not return latched byte");

  a_temp_direct: assert property (
    tmpWe && !(dsEn && isStkLo) |=> tmpByte == $past(tmpWdata))
    else $error("direct temp write lost");

  a_ext_load_addr: assert property (
    pmEn && pmExt
      |=> pmAddr == {$past(pageRead), $past(regs[5'h1f]), $past(regs[5'h1e])})
    else $error("extended load address not page and pointer");

  a_plain_load_page: assert property (
    pmEn && !pmExt |=> pmAddr == {8'h00, $past(zPtr)})
    else $error("plain program load used the page register");

  a_postinc_addr: assert property (
    ptrEn && ptrMode == PTR_POSTINC
      |=> ptrAddr == $past(pif.ptrValue))
    else $error("post-increment address wrong");

  a_predec_addr: assert property (
    ptrEn && ptrMode == PTR_PREDEC
      |=> ptrAddr == $past(pif.ptrValue) - 16'h0001)
    else $error("pre-decrement address wrong");

  a_reg_read_ds: assert property (
    dsRead && isReg |=> dsRdata == $past(regs[dsEff[4:0]]))
    else $error("data-space read of working register wrong");

  a_io_map: assert property (
    dsEn && dsIsIo && dsAddr[5:0] == 6'h3d |-> isStkLo)
    else $error("io address not moved up by 0x20");

  a_unmapped_zero: assert property (
    dsEn && !(isReg || isStkLo || isStkHi || isPage)
      |=> !dsHit && dsRdata == 8'h00)
    else $error("unmapped address answered");

  a_wide_write: assert property (
    wrEn && wrWide
      |=> {regs[{$past(wrAddr[4:1]), 1'b1}], regs[{$past(wrAddr[4:1]), 1'b0}]} == $past(wrData))
    else $error("wide write did not fill the pair");

  a_read_old_val: assert property (
    wrEn && !wrWide && wrAddr == rdAddrB |=> operandB == $past(regs[wrAddr]))
    else $error("same-cycle read saw new value");

  c_push_pop: cover property (stkOp == STK_PUSH ##1 stkOp == STK_POP);
  c_stack_pair_write: cover property (dsWrite && isStkLo ##1 stkWrite);
  c_pair_read: cover property (dsRead && isStkLo ##1 dsRead && isStkHi);
  c_ext_load: cover property (pmEn && pmExt && pageRead != 8'h00);
  c_wide_write: cover property (wrEn && wrWide);
endmodule
`default_nettype wire

/* File: include/rfs_cfg.svh */
/*
  rfs_cfg.svh: addresses, masks, reset values of the register file block.
  assumes: included by bare name, definitions only.
*/
`ifndef RFS_CFG_SVH
`define RFS_CFG_SVH
// ==========================================
// register file
`define RFS_NREG      32
`define RFS_REG_TOP   16'h001f
`define RFS_PTR_BASE  5'h1a
// ==========================================
// data-space map
`define RFS_IO_OFS    16'h0020
`define RFS_A_PAGE    16'h005b
`define RFS_A_STK_LO  16'h005d
`define RFS_A_STK_HI  16'h005e
// ==========================================
// reset values and masks
`define RFS_STK_RST   16'h10ff
`define RFS_STK_MASK  16'h1fff
`define RFS_PAGE_RST  8'h00
`define RFS_PAGE_MASK 8'h01
`define RFS_REG_RST   8'h00
`endif

/* File: include/rfs_pkg.sv */
/*
  rfs_pkg: types shared by the register file and its pointer unit.
  assumes: nothing.
*/
package rfs_pkg;
  typedef enum logic [2:0] {
    STK_NONE   = 3'b000,
    STK_PUSH   = 3'b001,
    STK_POP    = 3'b010,
    STK_CALL   = 3'b011,
    STK_RETURN = 3'b100
  } rfs_stk_t;
  typedef enum logic [1:0] {
    PTR_DISP    = 2'b00,
    PTR_POSTINC = 2'b01,
    PTR_PREDEC  = 2'b10
  } rfs_pmode_t;
endpackage

/* File: include/rfs_ptr_if.sv */
/*
  rfs_ptr_if: pointer and stack arithmetic between core and pointer unit.
  assumes: purely combinational traffic inside one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface rfs_ptr_if;
  import rfs_pkg::*;
  logic [15:0] ptrValue;
  rfs_pmode_t  ptrMode;
  logic [5:0]  ptrDisp;
  logic [15:0] effAddr;
  logic [15:0] newPtr;
  logic [15:0] stkValue;
  rfs_stk_t    stkOp;
  logic [15:0] next_stk;
  modport unit (input ptrValue, ptrMode, ptrDisp, stkValue, stkOp,
                output effAddr, newPtr, next_stk);
  modport core (output ptrValue, ptrMode, ptrDisp, stkValue, stkOp,
                input effAddr, newPtr, next_stk);
endinterface
`default_nettype wire

/* File: hdl/rfs_ptr_unit.sv */
/*
  rfs_ptr_unit: pointer address modes and stack pointer adjustment.
  assumes: core holds the registers and decides when results are kept.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rfs_cfg.svh"
module rfs_ptr_unit
  import rfs_pkg::*;
(
  rfs_ptr_if.unit pif
);
  // ==========================================
  // pointer modes
  wire [15:0] ptrInc  = pif.ptrValue + 16'h0001;
  wire [15:0] ptrDec  = pif.ptrValue - 16'h0001;
  wire [15:0] ptrDisp = pif.ptrValue + {10'h000, pif.ptrDisp};

  always_comb begin
    case (pif.ptrMode)
      PTR_POSTINC: begin
        pif.effAddr = pif.ptrValue;
        pif.newPtr  = ptrInc;
      end
      PTR_PREDEC: begin
        pif.effAddr = ptrDec;
        pif.newPtr  = ptrDec;
      end
      default: begin
        pif.effAddr = ptrDisp;
        pif.newPtr  = pif.ptrValue;
      end
    endcase
  end

  // ==========================================
  // stack: grows downward, upper bits masked off
  always_comb begin
    case (pif.stkOp)
      STK_PUSH:   pif.next_stk = (pif.stkValue - 16'h0001) & `RFS_STK_MASK;
      STK_POP:    pif.next_stk = (pif.stkValue + 16'h0001) & `RFS_STK_MASK;
      STK_CALL:   pif.next_stk = (pif.stkValue - 16'h0002) & `RFS_STK_MASK;
      STK_RETURN: pif.next_stk = (pif.stkValue + 16'h0002) & `RFS_STK_MASK;
      default:    pif.next_stk = pif.stkValue;
    endcase
  end
endmodule
`default_nettype wire

/* File: tb/rfs_core_model.sv */
/*
  rfs_core_model: core-side model of the data-space port and temp byte.
  assumes: one clock; the bench calls its tasks and samples 1 ns after
  the answering edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rfs_core_model (
  input  wire logic        clock,
  input  wire logic [7:0]  dsRdata,
  output var  logic        dsEn,
  output var  logic        dsWe,
  output var  logic        dsIsIo,
  output var  logic [15:0] dsAddr,
  output var  logic [7:0]  dsWdata,
  output var  logic        tmpWe,
  output var  logic [7:0]  tmpWdata
);
  initial begin
    {dsEn, dsWe, dsIsIo, tmpWe} = 4'h0;
    dsAddr = 16'h0000;
    {dsWdata, tmpWdata} = 16'h0000;
  end
  // ==========================================
  // single access; data line turned over on release so it never lingers
  task automatic acc(input logic we, input logic io, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge clock);
    dsEn <= 1'b1;
    dsWe <= we;
    dsIsIo <= io;
    dsAddr <= a;
    dsWdata <= d;
    @(posedge clock);
    dsEn <= 1'b0;
    dsWdata <= ~d;
    #1;
  endtask
  // the pair runs low byte first, with one idle cycle between the two stores
  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    acc(1'b1, 1'b0, a, v[7:0]);
    acc(1'b1, 1'b0, a + 16'h0001, v[15:8]);
  endtask
  task automatic tmp(input logic [7:0] d);
    @(posedge clock);
    tmpWe <= 1'b1;
    tmpWdata <= d;
    @(posedge clock);
    tmpWe <= 1'b0;
    tmpWdata <= ~d;
    #1;
  endtask
  // back-to-back pair read, low byte first, so the latch is really exercised
  task automatic rd16(input logic [15:0] a, output logic [15:0] v);
    @(posedge clock);
    dsEn <= 1'b1;
    dsWe <= 1'b0;
    dsIsIo <= 1'b0;
    dsAddr <= a;
    @(posedge clock);
    dsAddr <= a + 16'h0001;
    #1;
    v[7:0] = dsRdata;
    @(posedge clock);
    dsEn <= 1'b0;
    #1;
    v[15:8] = dsRdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  tb: self-checking bench of the register file block.
  assumes: rfs_core_model owns the data-space and temp-byte inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rfs_pkg::*;
  logic        clock = 1'b0, reset = 1'b1;
  logic [4:0]  rdAddrA = 5'h00, rdAddrB = 5'h00, wrAddr = 5'h00;
  logic        rdWide = 1'b0, wrEn = 1'b0, wrWide = 1'b0, ptrEn = 1'b0;
  logic        pmEn = 1'b0, pmExt = 1'b0, dsEn, dsWe, dsIsIo, tmpWe, dsHit;
  logic [15:0] wrData = 16'h0000, dsAddr, operandA, ptrAddr, stackPtr;
  logic [1:0]  ptrSel = 2'h0;
  logic [5:0]  ptrDisp = 6'h00;
  rfs_pmode_t  ptrMode = PTR_DISP;
  rfs_stk_t    stkOp = STK_NONE;
  logic [7:0]  dsWdata, tmpWdata, operandB, dsRdata, tmpByte;
  logic [23:0] pmAddr;
  int          error_cnt = 0, num_checks = 0;
  rfs_regfile rfs_regfile_i (
    .clock    (clock),
    .reset    (reset),
    .rdAddrA  (rdAddrA),
    .rdAddrB  (rdAddrB),
    .rdWide   (rdWide),
    .wrEn     (wrEn),
    .wrWide   (wrWide),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .ptrEn    (ptrEn),
    .ptrSel   (ptrSel),
    .ptrMode  (ptrMode),
    .ptrDisp  (ptrDisp),
    .stkOp    (stkOp),
    .pmEn     (pmEn),
    .pmExt    (pmExt),
    .dsEn     (dsEn),
    .dsWe     (dsWe),
    .dsIsIo   (dsIsIo),
    .dsAddr   (dsAddr),
    .dsWdata  (dsWdata),
    .tmpWe    (tmpWe),
    .tmpWdata (tmpWdata),
    .operandA (operandA),
    .operandB (operandB),
    .ptrAddr  (ptrAddr),
    .pmAddr   (pmAddr),
    .dsRdata  (dsRdata),
    .dsHit    (dsHit),
    .stackPtr (stackPtr),
    .tmpByte  (tmpByte)
  );
  rfs_core_model rfs_core_model_i (
    .clock    (clock),
    .dsRdata  (dsRdata),
    .dsEn     (dsEn),
    .dsWe     (dsWe),
    .dsIsIo   (dsIsIo),
    .dsAddr   (dsAddr),
    .dsWdata  (dsWdata),
    .tmpWe    (tmpWe),
    .tmpWdata (tmpWdata)
  );
  always #25 clock = ~clock;
  // ==========================================
  // shared tasks
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic ds(input logic we, input logic io, input logic [15:0] a,
                    input logic [7:0] d);
    rfs_core_model_i.acc(we, io, a, d);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic w);
    @(posedge clock);
    {wrEn, wrAddr, wrData, wrWide} <= {1'b1, a, d, w};
    @(posedge clock);
    wrEn <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [4:0] b, input logic w);
    @(posedge clock);
    {rdAddrA, rdAddrB, rdWide} <= {a, b, w};
    @(posedge clock);
    #1;
  endtask
  task automatic stk(input rfs_stk_t op);
    @(posedge clock);
    stkOp <= op;
    @(posedge clock);
    stkOp <= STK_NONE;
    #1;
  endtask
  task automatic ptr(input logic [1:0] s, input rfs_pmode_t m, input logic [5:0] d);
    @(posedge clock);
    {ptrEn, ptrSel, ptrDisp} <= {1'b1, s, d};
    ptrMode <= m;
    @(posedge clock);
    ptrEn <= 1'b0;
    #1;
  endtask
  task automatic pm(input logic x);
    @(posedge clock);
    {pmEn, pmExt} <= {1'b1, x};
    @(posedge clock);
    pmEn <= 1'b0;
    #1;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    chk("stack", 16'h10ff, stackPtr);
    ds(1'b0, 1'b0, 16'h005b, 8'h00);
    chk("page", 8'h00, dsRdata);
    chk("hit", 1'b1, dsHit);
    $display("test reset done");
  endtask
  task automatic t_stack;
    rfs_stk_t ops[4] = '{STK_PUSH, STK_CALL, STK_POP, STK_RETURN};
    logic [15:0] dl[4] = '{16'hffff, 16'hfffe, 16'h0001, 16'h0002};
    logic [15:0] e = 16'h10ff;
    foreach (ops[i]) begin
      stk(ops[i]);
      e = e + dl[i];
      chk("stack op", e, stackPtr);
    end
    $display("test stack done");
  endtask
  task automatic t_stack16;
    logic [15:0] pair;
    rfs_core_model_i.acc(1'b1, 1'b0, 16'h005d, 8'hff);
    chk("tmp low", 8'hff, tmpByte);
    chk("stack hold", 16'h10ff, stackPtr);
    rfs_core_model_i.acc(1'b1, 1'b0, 16'h005e, 8'hff);
    chk("stack mask", 16'h1fff, stackPtr);
    rfs_core_model_i.wr16(16'h005d, 16'h0100);
    ds(1'b0, 1'b1, 16'h003d, 8'h00);
    chk("io low", 8'h00, dsRdata);
    chk("latch", 8'h01, tmpByte);
    stk(STK_PUSH);
    ds(1'b0, 1'b1, 16'h003e, 8'h00);
    chk("io high", 8'h01, dsRdata);
    rfs_core_model_i.wr16(16'h005d, 16'h0001);
    stk(STK_CALL);
    chk("stack wrap", 16'h1fff, stackPtr);
    rfs_core_model_i.rd16(16'h005d, pair);
    chk("pair read", 16'h1fff, pair);
    $display("test stack16 done");
  endtask
  task automatic t_regs;
    wr(5'd30, 16'h0100, 1'b1);
    rd(5'd30, 5'd31, 1'b1);
    chk("wide", 16'h0100, operandA);
    chk("opB", 8'h01, operandB);
    ds(1'b0, 1'b0, 16'h001f, 8'h00);
    chk("ds reg", 8'h01, dsRdata);
    ds(1'b1, 1'b0, 16'h0003, 8'ha5);
    rd(5'd3, 5'd3, 1'b0);
    chk("ds wr", 16'h00a5, operandA);
    @(posedge clock);
    {wrEn, wrAddr, wrData, wrWide} <= {1'b1, 5'd3, 16'h005a, 1'b0};
    @(posedge clock);
    wrEn <= 1'b0;
    #1;
    chk("old", 16'h00a5, operandA);
    chk("old b", 8'ha5, operandB);
    @(posedge clock);
    #1;
    chk("new", 16'h005a, operandA);
    $display("test regs done");
  endtask
  task automatic t_ptr;
    ptr(2'd2, PTR_POSTINC, 6'h00);
    chk("post addr", 16'h0100, ptrAddr);
    rd(5'd30, 5'd0, 1'b1);
    chk("post z", 16'h0101, operandA);
    ptr(2'd2, PTR_PREDEC, 6'h00);
    chk("pre addr", 16'h0100, ptrAddr);
    ptr(2'd2, PTR_DISP, 6'h3f);
    chk("disp", 16'h013f, ptrAddr);
    wr(5'd26, 16'h0003, 1'b1);
    ptr(2'd0, PTR_DISP, 6'h00);
    chk("x addr", 16'h0003, ptrAddr);
    ds(1'b0, 1'b0, ptrAddr, 8'h00);
    chk("x reg", 8'h5a, dsRdata);
    wr(5'd28, 16'h0205, 1'b1);
    ptr(2'd1, PTR_POSTINC, 6'h00);
    chk("y addr", 16'h0205, ptrAddr);
    $display("test ptr done");
  endtask
  task automatic t_page;
    ds(1'b1, 1'b0, 16'h005b, 8'hff);
    ds(1'b0, 1'b0, 16'h005b, 8'h00);
    chk("page bits", 8'h01, dsRdata);
    pm(1'b1);
    chk("ext", 24'h010100, pmAddr);
    pm(1'b0);
    chk("plain", 24'h000100, pmAddr);
    ds(1'b0, 1'b0, 16'h0040, 8'h00);
    chk("unmapped", 9'h000, {dsHit, dsRdata});
    rfs_core_model_i.tmp(8'h3c);
    chk("tmp", 8'h3c, tmpByte);
    $display("test page done");
  endtask
  task automatic t_mid_reset;
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("stack rst", 16'h10ff, stackPtr);
    chk("tmp rst", 8'h00, tmpByte);
    ds(1'b0, 1'b0, 16'h005b, 8'h00);
    chk("page rst", 8'h00, dsRdata);
    rd(5'd30, 5'd31, 1'b1);
    chk("reg rst", 16'h0000, operandA);
    $display("test mid reset done");
  endtask
  // ==========================================
  // main sequence; the watchdog cuts a hang short
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_stack();
    t_stack16();
    t_regs();
    t_ptr();
    t_page();
    t_mid_reset();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
